// *** common/interlock_defines.vh ***
`ifndef INTERLOCK_DEFINES_VH
`define INTERLOCK_DEFINES_VH
// clock rate
`define CLK_HZ              20000000
// standby cooling duty cycle, printed in minutes
`define COOL_ON_MIN         2
`define COOL_OFF_MIN        3
`define COOL_ON_CYC         (`COOL_ON_MIN * 60 * `CLK_HZ)
`define COOL_OFF_CYC        (`COOL_OFF_MIN * 60 * `CLK_HZ)
// cooling enabled only below this setpoint, degrees C
`define COOL_LIMIT_DEGC     8'h14
// pulses per revolution
`define TOP_PPR             4'h6
`define BOTTOM_PPR          4'h1
// seconds per minute, for rpm
`define SEC_PER_MIN         16'h3c
// overspeed error code 61.19 as two bcd bytes
`define ERR_OVERSPEED       16'h6119
`define ERR_NONE            16'h0000
// program store
`define PROG_COUNT          99
`define PROG_AW             7
// standstill timeout default, cycles (one second)
`define STANDSTILL_CYC      20000000
// heartbeat loss timeout default, cycles
`define HEARTBEAT_CYC       200000
// consecutive bad check sums before link fault
`define LINK_FAIL_MAX       4'h3
// green flash half period, cycles
`define FLASH_CYC           5000000
// run states, one hot
`define ST_IDLE             5'h01
`define ST_RUNUP            5'h02
`define ST_SPIN             5'h04
`define ST_BRAKE            5'h08
`define ST_FAULT            5'h10
`endif

// *** hdl/link_checker.v ***
`timescale 1ns/1ns
`default_nettype none
`include "interlock_defines.vh"
// ************************************************************
// message check sum and peer supervision
// ************************************************************
module link_checker #(
  parameter integer heartbeat_cyc = `HEARTBEAT_CYC
) (
  input  wire        clk,
  input  wire        rst,
  input  wire        msg_valid,
  input  wire [31:0] msg_data,
  input  wire [7:0]  msg_sum,
  input  wire [3:0]  fail_limit,
  output reg         msg_good,
  output reg         link_fault,
  output reg         peer_dead
);
  reg  [3:0]  fail_count;
  reg  [31:0] silent;
  wire [7:0]  sum_calc = msg_data[31:24] + msg_data[23:16] + msg_data[15:8] + msg_data[7:0];
  wire        sum_ok   = (sum_calc == msg_sum); // RULE20
  // check sum verify and consecutive failure count
  always @(posedge clk) begin
    if (rst) begin
      fail_count <= 4'h0;
      link_fault <= 1'b0;
      msg_good   <= 1'b0;
    end else begin
      msg_good <= msg_valid & sum_ok; // RULE24
      if (msg_valid & sum_ok) begin
        fail_count <= 4'h0;
      end else if (msg_valid & (fail_count != 4'hf)) begin
        fail_count <= fail_count + 4'h1;
      end
      if (msg_valid & ~sum_ok & (fail_count + 4'h1 >= fail_limit)) begin
        link_fault <= 1'b1; // RULE24
      end
    end
  end
  // peer supervision: good messages act as heartbeat
  always @(posedge clk) begin
    if (rst) begin
      silent    <= 32'h0;
      peer_dead <= 1'b0;
    end else if (msg_valid & sum_ok) begin
      silent <= 32'h0;
    end else if (silent >= heartbeat_cyc - 1) begin
      peer_dead <= 1'b1; // RULE19
    end else begin
      silent <= silent + 32'h1;
    end
  end
endmodule // link_checker
`default_nettype wire

// *** hdl/centrifuge_safety_interlock_ctrl.v ***
`timescale 1ns/1ns
`default_nettype none
`include "interlock_defines.vh"
// How it works
// RULE1: lid unlock only at rotor standstill
// RULE2: release key drives lid actuator open
// RULE3: lock needs both contacts, position, standstill
// RULE4: run start refused unless lid closed
// RULE5: imbalance evaluated only in running states
// RULE6: imbalance stops drive, brakes rotor
// RULE7: overspeed stops drive, reports code 61.19
// RULE8: speed from top sensor, six pulses
// RULE9: bottom sensor pulse qualifies lid release
// RULE10: standby cooling only if setpoint below 20C
// RULE11: compressor two minutes on, three off
// RULE12: lid open switches cooling off
// RULE13: chamber overtemperature switch stops drive
// RULE14: motor overtemperature switch stops drive
// RULE15: fan speed follows condenser temperature
// RULE16: green steady normally, flashing on error
// RULE17: yellow lit while everything is fine
// RULE18: any drive error stops the motor
// RULE19: lost peer stops the drive
// RULE20: link messages carry verified check sum
// RULE21: safety contacts are break contacts
// RULE22: storage for 99 run programs
// RULE23: standstill after pulse-free timeout
// RULE24: bad sums ignored, fault after limit
module centrifuge_safety_interlock_ctrl #(
  parameter integer standstill_cyc = `STANDSTILL_CYC,
  parameter integer cool_on_cyc    = `COOL_ON_CYC,
  parameter integer cool_off_cyc   = `COOL_OFF_CYC,
  parameter integer flash_cyc      = `FLASH_CYC,
  parameter integer heartbeat_cyc  = `HEARTBEAT_CYC
) (
  input  wire        clk,
  input  wire        rst,
  input  wire        left_lid_contact,
  input  wire        right_lid_contact,
  input  wire        lid_opened_position_contact,
  input  wire        top_tacho_sensor,
  input  wire        bottom_tacho_sensor,
  input  wire        imbalance_sensor,
  input  wire        chamber_overtemp_ok,
  input  wire        motor_overtemp_ok,
  input  wire [7:0]  chamber_temp_sensor,
  input  wire [7:0]  condenser_temp_sensor,
  input  wire [7:0]  temp_setpoint,
  input  wire [15:0] speed_limit,
  input  wire [3:0]  rotor_code_in,
  input  wire        lid_release_key,
  input  wire        start_key,
  input  wire        stop_key,
  input  wire        drive_error,
  input  wire        msg_valid,
  input  wire [31:0] msg_data,
  input  wire [7:0]  msg_sum,
  input  wire [3:0]  link_fail_limit,
  input  wire        prog_we,
  input  wire [6:0]  prog_addr,
  input  wire [31:0] prog_wdata,
  output reg  [31:0] prog_rdata,
  output reg         lid_lock_actuator,
  output reg         lid_open_drive,
  output reg         drive_motor,
  output reg         drive_brake,
  output reg         compressor,
  output reg  [7:0]  condenser_fan,
  output reg         green_led,
  output reg         yellow_led,
  output reg  [15:0] error_code,
  output reg  [15:0] rotor_speed,
  output reg  [3:0]  rotor_code,
  output reg         standstill,
  output reg  [4:0]  run_state
);
  // ************************************************************
  // input conditioning
  // ************************************************************
  // break contacts: an open wire reads as actuated, lid open or overtemperature trip
  wire lid_closed   = left_lid_contact & right_lid_contact; // RULE21
  wire chamber_trip = ~chamber_overtemp_ok; // RULE21
  wire motor_trip   = ~motor_overtemp_ok; // RULE21
  reg  top_d;
  reg  bot_d;
  wire top_edge = top_tacho_sensor & ~top_d;
  wire bot_edge = bottom_tacho_sensor & ~bot_d;
  always @(posedge clk) begin
    if (rst) begin
      top_d <= 1'b0;
      bot_d <= 1'b0;
    end else begin
      top_d <= top_tacho_sensor;
      bot_d <= bottom_tacho_sensor;
    end
  end
  // ************************************************************
  // standstill detect
  // ************************************************************
  reg [31:0] quiet_count;
  reg [31:0] bot_quiet;
  reg        bottom_still;
  always @(posedge clk) begin
    if (rst) begin
      quiet_count  <= 32'h0;
      bot_quiet    <= 32'h0;
      standstill   <= 1'b0;
      bottom_still <= 1'b0;
    end else begin
      if (top_edge | bot_edge) begin
        quiet_count <= 32'h0; // RULE23
        standstill  <= 1'b0;
      end else if (quiet_count >= standstill_cyc - 1) begin
        standstill <= 1'b1; // RULE23
      end else begin
        quiet_count <= quiet_count + 32'h1;
      end
      if (bot_edge) begin
        bot_quiet    <= 32'h0; // RULE9
        bottom_still <= 1'b0;
      end else if (bot_quiet >= standstill_cyc - 1) begin
        bottom_still <= 1'b1; // RULE9
      end else begin
        bot_quiet <= bot_quiet + 32'h1;
      end
    end
  end
  // ************************************************************
  // speed measure from top tacho: pulses per second / 6 * 60 = rpm
  // ************************************************************
  reg [31:0] gate_count;
  reg [15:0] pulse_count;
  always @(posedge clk) begin
    if (rst) begin
      gate_count  <= 32'h0;
      pulse_count <= 16'h0;
      rotor_speed <= 16'h0;
      rotor_code  <= 4'h0;
    end else begin
      if (gate_count >= `CLK_HZ - 1) begin
        gate_count  <= 32'h0;
        pulse_count <= 16'h0;
        // rpm = pulses per second * 60 / pulses per revolution
        rotor_speed <= (pulse_count * `SEC_PER_MIN) / {12'h0, `TOP_PPR}; // RULE8
      end else begin
        gate_count <= gate_count + 32'h1;
        if (top_edge) begin
          pulse_count <= pulse_count + 16'h1; // RULE8
        end
      end
      // rotor code latched from rotor_code_in at the first top pulse after standstill
      if (top_edge & standstill) begin
        rotor_code <= rotor_code_in; // RULE8
      end
    end
  end
  // ************************************************************
  // link supervision
  // ************************************************************
  wire link_fault;
  wire peer_dead;
  link_checker #(.heartbeat_cyc(heartbeat_cyc)) u_link (
    .clk        (clk),
    .rst        (rst),
    .msg_valid  (msg_valid),
    .msg_data   (msg_data),
    .msg_sum    (msg_sum),
    .fail_limit (link_fail_limit),
    .msg_good   (),
    .link_fault (link_fault),
    .peer_dead  (peer_dead)
  );
  // ************************************************************
  // run state machine and drive shutdown
  // ************************************************************
  wire running   = run_state[1] | run_state[2] | run_state[3];
  wire imbalance = imbalance_sensor & running; // RULE5
  wire overspeed = running & (rotor_speed > speed_limit); // RULE7
  wire hard_trip = chamber_trip | motor_trip | drive_error | peer_dead | link_fault | overspeed;
  reg  [4:0] next_state;
  always @* begin
    next_state = run_state;
    case (run_state)
      `ST_IDLE: begin
        if (start_key & lid_closed & ~hard_trip) begin
          next_state = `ST_RUNUP; // RULE4
        end
      end
      `ST_RUNUP: begin
        if (hard_trip) begin
          next_state = `ST_FAULT;
        end else if (imbalance | stop_key | ~lid_closed) begin
          next_state = `ST_BRAKE; // RULE6
        end else if (rotor_speed >= speed_limit) begin
          next_state = `ST_SPIN;
        end
      end
      `ST_SPIN: begin
        if (hard_trip) begin
          next_state = `ST_FAULT;
        end else if (imbalance | stop_key | ~lid_closed) begin
          next_state = `ST_BRAKE; // RULE6
        end
      end
      `ST_BRAKE: begin
        if (hard_trip) begin
          next_state = `ST_FAULT;
        end else if (standstill) begin
          next_state = `ST_IDLE;
        end
      end
      `ST_FAULT: begin
        if (~hard_trip & standstill & stop_key) begin
          next_state = `ST_IDLE;
        end
      end
      default: next_state = `ST_IDLE;
    endcase
  end
  always @(posedge clk) begin
    if (rst) begin
      run_state   <= `ST_IDLE;
      drive_motor <= 1'b0;
      drive_brake <= 1'b0;
      error_code  <= `ERR_NONE;
    end else begin
      run_state   <= next_state;
      // motor off whenever not accelerating or holding speed
      drive_motor <= (next_state == `ST_RUNUP) | (next_state == `ST_SPIN); // RULE13 RULE14 RULE18 RULE19
      drive_brake <= (next_state == `ST_BRAKE); // RULE6
      if (overspeed) begin
        error_code <= `ERR_OVERSPEED; // RULE7
      end else if ((run_state == `ST_FAULT) & (next_state == `ST_IDLE)) begin
        error_code <= `ERR_NONE;
      end
    end
  end
  // ************************************************************
  // lid lock
  // ************************************************************
  always @(posedge clk) begin
    if (rst) begin
      lid_lock_actuator <= 1'b0;
      lid_open_drive    <= 1'b0;
    end else begin
      if (lid_release_key & standstill & bottom_still & ~running) begin
        lid_lock_actuator <= 1'b0; // RULE1
        lid_open_drive    <= 1'b1; // RULE2
      end else if (lid_closed & lid_opened_position_contact & standstill) begin
        lid_lock_actuator <= 1'b1; // RULE3
        lid_open_drive    <= 1'b0;
      end else begin
        lid_open_drive <= 1'b0;
      end
    end
  end
  // ************************************************************
  // standby cooling and condenser fan
  // ************************************************************
  reg [31:0] cool_count;
  reg        cool_phase;
  wire       cool_allow = standstill & lid_closed & (temp_setpoint < `COOL_LIMIT_DEGC); // RULE10
  always @(posedge clk) begin
    if (rst) begin
      cool_count <= 32'h0;
      cool_phase <= 1'b1;
      compressor <= 1'b0;
    end else if (~cool_allow | ~lid_closed) begin
      cool_count <= 32'h0; // RULE12
      cool_phase <= 1'b1;
      compressor <= 1'b0; // RULE12
    end else begin
      compressor <= cool_phase & (chamber_temp_sensor > temp_setpoint);
      if (cool_phase & (cool_count >= cool_on_cyc - 1)) begin
        cool_phase <= 1'b0; // RULE11
        cool_count <= 32'h0;
      end else if (~cool_phase & (cool_count >= cool_off_cyc - 1)) begin
        cool_phase <= 1'b1; // RULE11
        cool_count <= 32'h0;
      end else begin
        cool_count <= cool_count + 32'h1;
      end
    end
  end
  // fan duty tracks condenser temperature while compressor runs
  always @(posedge clk) begin
    if (rst) begin
      condenser_fan <= 8'h00;
    end else begin
      condenser_fan <= compressor ? condenser_temp_sensor : 8'h00; // RULE15
    end
  end
  // ************************************************************
  // status leds
  // ************************************************************
  reg [31:0] flash_count;
  reg        flash;
  wire       any_error = (run_state == `ST_FAULT) | hard_trip;
  always @(posedge clk) begin
    if (rst) begin
      flash_count <= 32'h0;
      flash       <= 1'b0;
      green_led   <= 1'b0;
      yellow_led  <= 1'b0;
    end else begin
      if (flash_count >= flash_cyc - 1) begin
        flash_count <= 32'h0;
        flash       <= ~flash;
      end else begin
        flash_count <= flash_count + 32'h1;
      end
      green_led  <= any_error ? flash : 1'b1; // RULE16
      yellow_led <= ~any_error & ~imbalance; // RULE17
    end
  end
  // ************************************************************
  // run program store
  // ************************************************************
  reg [31:0] prog_mem [0:`PROG_COUNT-1];
  always @(posedge clk) begin
    if (prog_we & (prog_addr < `PROG_COUNT)) begin
      prog_mem[prog_addr] <= prog_wdata; // RULE22
    end
    if (rst) begin
      prog_rdata <= 32'h0;
    end else begin
      prog_rdata <= (prog_addr < `PROG_COUNT) ? prog_mem[prog_addr] : 32'h0;
    end
  end
endmodule // centrifuge_safety_interlock_ctrl
`default_nettype wire

// *** verif/sensor_model.sv ***
`timescale 1ns/1ns
`default_nettype none
// ************************************************************
// contacts and tacho sensors around the rotor
// ************************************************************
module sensor_model (
  input  wire logic clk,
  input  wire logic motor_on,
  input  wire logic lid_shut,
  output wire logic left_lid_contact,
  output wire logic right_lid_contact,
  output wire logic lid_opened_position_contact,
  output wire logic top_tacho_sensor,
  output wire logic bottom_tacho_sensor
);
  logic [4:0] ph = 5'h00;
  // break contacts: an open lid reads as an open circuit
  assign left_lid_contact = lid_shut;
  assign right_lid_contact = lid_shut;
  assign lid_opened_position_contact = lid_shut;
  // one revolution is 24 cycles; no pulses once the motor stops
  always @(posedge clk) begin
    ph <= (!motor_on || ph == 5'h17) ? 5'h00 : ph + 5'h01;
  end
  assign top_tacho_sensor = motor_on & ph[1];
  assign bottom_tacho_sensor = motor_on & (ph[4:2] == 3'h0) & ph[1];
endmodule // sensor_model
`default_nettype wire

// *** verif/interlock_asserts.sv ***
`timescale 1ns/1ns
`default_nettype none
// ************************************************************
// interlock checker
// ************************************************************
module interlock_asserts #(
  parameter integer cool_on_cyc = 20
) (
  input wire logic       clk,
  input wire logic       rst,
  input wire logic       left_lid_contact,
  input wire logic       right_lid_contact,
  input wire logic       lid_opened_position_contact,
  input wire logic       imbalance_sensor,
  input wire logic       chamber_overtemp_ok,
  input wire logic       motor_overtemp_ok,
  input wire logic       drive_error,
  input wire logic [7:0] condenser_temp_sensor,
  input wire logic [7:0] temp_setpoint,
  input wire logic       lid_lock_actuator,
  input wire logic       lid_open_drive,
  input wire logic       drive_motor,
  input wire logic       drive_brake,
  input wire logic       compressor,
  input wire logic [7:0] condenser_fan,
  input wire logic       standstill,
  input wire logic [4:0] run_state
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  // a trip keeps the drive off for the next two cycles
  sequence s_off2;
    !drive_motor ##1 !drive_motor;
  endsequence
  logic [31:0] on_cnt;
  // length of the current compressor on stretch
  always @(posedge clk) begin
    on_cnt <= (rst || !compressor) ? 32'h0 : on_cnt + 32'h1;
  end
  a_unlock_standstill: assert property ($fell(lid_lock_actuator) |-> $past(standstill))
    else $error("lid unlocked while rotor turning");
  a_open_standstill: assert property ($rose(lid_open_drive) |-> $past(standstill))
    else $error("lid opened while rotor turning");
  a_lock_contacts: assert property ($rose(lid_lock_actuator) |->
    $past(left_lid_contact && right_lid_contact && lid_opened_position_contact && standstill))
    else $error("lid locked without contacts");
  a_start_lid: assert property ($rose(drive_motor) |-> $past(left_lid_contact && right_lid_contact))
    else $error("run started with lid open");
  a_imbalance_stop: assert property (imbalance_sensor && (run_state & 5'h0e) != 5'h00
    |=> !drive_motor && drive_brake)
    else $error("imbalance did not brake");
  a_chamber_trip: assert property (!chamber_overtemp_ok |=> s_off2)
    else $error("chamber trip left drive on");
  a_motor_trip: assert property (!motor_overtemp_ok |=> s_off2)
    else $error("motor trip left drive on");
  a_drive_err: assert property (drive_error |=> s_off2)
    else $error("drive error left motor on");
  a_cool_lid: assert property (!(left_lid_contact && right_lid_contact) |=> !compressor)
    else $error("cooling on with lid open");
  a_cool_limit: assert property (temp_setpoint >= 8'h14 && standstill |=> !compressor)
    else $error("standby cooling above limit");
  a_fan_follow: assert property (compressor && $stable(condenser_temp_sensor)
    |=> !compressor || condenser_fan == $past(condenser_temp_sensor))
    else $error("fan not following condenser");
  a_cool_duty: assert property (on_cnt <= cool_on_cyc)
    else $error("compressor on phase too long");
endmodule // interlock_asserts
bind centrifuge_safety_interlock_ctrl interlock_asserts #(.cool_on_cyc(cool_on_cyc)) rules (.*);
`default_nettype wire

// *** verif/tb_top.sv ***
`timescale 1ns/1ns
`default_nettype none
module tb_top;
  // ************************************************************
  // stimulus and observed signals
  // ************************************************************
  localparam int on_cyc = 20;
  localparam int off_cyc = 30;
  logic        clk = 0, rst = 1, lid_shut = 0, imbalance_sensor = 0, drive_error = 0;
  logic        chamber_overtemp_ok = 1, motor_overtemp_ok = 1, lid_release_key = 0;
  logic        start_key = 0, stop_key = 0, msg_valid = 0, prog_we = 0, hb_en = 1;
  logic [7:0]  chamber_temp_sensor = 0, condenser_temp_sensor = 0, temp_setpoint = 0;
  logic [7:0]  msg_sum = 0, condenser_fan;
  logic [15:0] speed_limit = 16'hffff, error_code, rotor_speed;
  logic [3:0]  rotor_code_in = 0, link_fail_limit = 4'h3, rotor_code;
  logic [6:0]  prog_addr = 0;
  logic [31:0] prog_wdata = 0, msg_data = 0, meas = 0, pdata, prog_rdata, e;
  logic        left_lid_contact, right_lid_contact, lid_opened_position_contact;
  logic        top_tacho_sensor, bottom_tacho_sensor, lid_lock_actuator, lid_open_drive;
  logic        drive_motor, drive_brake, compressor, green_led, yellow_led, standstill;
  logic [4:0]  run_state;
  int          fail_count = 0, checked = 0, bad = 0, k, i, s;
  int          sel_q[$];
  logic [31:0] exp_q[$];
  centrifuge_safety_interlock_ctrl #(.standstill_cyc(16), .cool_on_cyc(on_cyc),
    .cool_off_cyc(off_cyc), .flash_cyc(8), .heartbeat_cyc(64)) dut (.*);
  sensor_model model (.motor_on(drive_motor), .*);
  // clock
  always #25 clk = ~clk;
  // heartbeat messages, a few with broken sums on request
  always begin
    repeat (16) @(posedge clk);
    #5;
    msg_data = $urandom;
    msg_sum = msg_data[7:0] + msg_data[15:8] + msg_data[23:16] + msg_data[31:24] + 8'(bad > 0);
    if (bad > 0) bad--;
    msg_valid = hb_en && !rst;
    @(posedge clk);
    #5 msg_valid = 0;
  end
  task tick(input int n);
    repeat (n) @(posedge clk);
    #5;
  endtask
  task chk(input int sel, input logic [31:0] v);
    sel_q.push_back(sel);
    exp_q.push_back(v);
  endtask
  task wait_ss;
    for (int j = 0; j < 200 && standstill !== 1'b1; j++) tick(1);
  endtask
  task measure(input logic l);
    logic [31:0] n;
    n = 0;
    while (compressor === l && n < 500) begin
      tick(1);
      n++;
    end
    meas = n; // published only when done, so a queued check still sees it
  endtask
  function automatic logic [31:0] got(input int sel);
    case (sel)
      0: got = 32'(run_state);
      1: got = 32'(drive_motor);
      2: got = 32'(lid_lock_actuator);
      3: got = 32'(lid_open_drive);
      4: got = 32'(compressor);
      5: got = 32'(standstill);
      6: got = 32'(yellow_led);
      7: got = 32'(green_led);
      8: got = prog_rdata;
      9: got = 32'(drive_brake);
      10: got = 32'(rotor_code);
      11: got = 32'(error_code);
      12: got = 32'(condenser_fan);
      default: got = meas;
    endcase
  endfunction
  // takes every queued note, oldest first, and compares it with the settled outputs
  always @(negedge clk) begin
    while (sel_q.size() > 0) begin
      s = sel_q.pop_front();
      e = exp_q.pop_front();
      checked++;
      if (got(s) !== e) begin
        fail_count++;
        $display("ERROR t=%0t exp=%h got=%h", $time, e, got(s));
      end
    end
  end
  task complete_run;
    $display("checks %0d mismatches %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  // watchdog
  initial begin
    #(20000 * 50);
    fail_count++;
    complete_run;
  end
  // ************************************************************
  // main sequence
  // ************************************************************
  initial begin
    void'($urandom(32'he301));
    temp_setpoint = 8'($urandom_range(19, 0));
    condenser_temp_sensor = 8'($urandom_range(255, 1));
    chamber_temp_sensor = 8'($urandom_range(255, 20)); // above any setpoint below 20
    rotor_code_in = 4'($urandom);
    tick(10);
    rst = 0;
    tick(1);
    chk(0, 5'h01);
    start_key = 1;
    tick(1);
    start_key = 0;
    chk(0, 5'h01);
    chk(4, 0);
    wait_ss;
    chk(5, 1);
    imbalance_sensor = 1;
    tick(3);
    chk(0, 5'h01);
    imbalance_sensor = 0;
    lid_shut = 1;
    tick(2);
    chk(2, 1);
    measure(1);
    measure(0);
    measure(1);
    chk(15, on_cyc);
    chk(12, condenser_temp_sensor);
    measure(0);
    chk(15, off_cyc);
    temp_setpoint = 8'h14;
    tick(2);
    chk(4, 0);
    temp_setpoint = 8'h13;
    measure(0);
    lid_shut = 0;
    tick(2);
    chk(4, 0);
    lid_shut = 1;
    tick(3);
    chk(7, 1);
    chk(6, 1);
    for (i = 0; i < 2; i++) begin
      prog_addr = i ? 7'h62 : 7'h00;
      pdata = $urandom;
      prog_wdata = pdata;
      prog_we = 1;
      tick(1);
      prog_we = 0;
      tick(1);
      chk(8, pdata);
    end
    lid_release_key = 1;
    tick(1);
    chk(3, 1);
    chk(2, 0);
    lid_release_key = 0;
    tick(1);
    lid_shut = 0;
    tick(2);
    lid_shut = 1;
    tick(3);
    chk(2, 1);
    for (k = 0; k < 6; k++) begin
      rotor_code_in = 4'($urandom);
      start_key = 1;
      tick(1);
      start_key = 0;
      chk(0, 5'h02);
      tick(40);
      chk(7, 1);
      chk(5, 0);
      chk(10, 32'(rotor_code_in));
      lid_release_key = 1;
      tick(2);
      lid_release_key = 0;
      chk(3, 0);
      case (k)
        0: imbalance_sensor = 1;
        1: chamber_overtemp_ok = 0;
        2: motor_overtemp_ok = 0;
        3: drive_error = 1;
        4: hb_en = 0;
        default: bad = 3;
      endcase
      tick(k < 4 ? 1 : 100);
      chk(1, 0);
      chk(6, 0);
      if (k == 0) chk(9, 1);
      {imbalance_sensor, drive_error, hb_en} = 3'b001;
      {chamber_overtemp_ok, motor_overtemp_ok} = 2'b11;
      wait_ss;
      if (k >= 4) begin
        // lost peer and link fault hold until reset: release it again mid-run
        rst = 1;
        tick(2);
        rst = 0;
        tick(1);
        chk(0, 5'h01);
        chk(1, 0);
        wait_ss;
      end
      stop_key = 1;
      tick(1);
      stop_key = 0;
      tick(1);
      chk(0, 5'h01);
      chk(11, 32'h0);
    end
    tick(2);
    complete_run;
  end
endmodule // tb_top
`default_nettype wire
